// ===== core/pdr_cfg.svh
`ifndef PDR_CFG_SVH
`define PDR_CFG_SVH

// Engine count; engines 0,1 are system_to_card, 2,3 card_to_system
`define PDR_NUM_ENG     4
`define PDR_C2S_BIT     1

// Descriptor traffic sizes in bytes
`define PDR_DESC_BYTES  8'h20
`define PDR_UPD_BYTES   8'h0c
`define PDR_MAX_PAYLOAD 20'h0_0080
`define PDR_BEAT_BYTES  20'h0_0008
`define PDR_ADDR_STEP   32'h0000_0020

// Register window: word index in [4:2], engine in [6:5]
`define PDR_REG_CTRL    3'h0
`define PDR_REG_START   3'h1
`define PDR_REG_END     3'h2
`define PDR_REG_NEXT    3'h3
`define PDR_REG_TAIL    3'h4
`define PDR_REG_DONE    3'h5
`define PDR_REG_STAT    3'h6
`define PDR_IDX_LSB     2
`define PDR_IDX_MSB     4
`define PDR_ENG_LSB     5
`define PDR_ENG_MSB     6
`define PDR_HI_LSB      7

// Descriptor beat 0 layout: length low, flags high
`define PDR_LEN_MSB     19
`define PDR_FLG_SOP     32
`define PDR_FLG_EOP     33
`define PDR_FLG_IRQ     34

// Update status word bits
`define PDR_ST_CMPL     0
`define PDR_ST_SOP      1
`define PDR_ST_EOP      2

`endif

// ===== core/pdr_dma_core.sv
// Notes on behaviour
// - Completed pointer holds last finished descriptor
// - Next pointer advances around ring per descriptor
// - Software tail pointer bounds engine progress
// - Packets span one or many descriptors
// - Engine writes completion status into descriptor
// - Receive update reports start, end, user status
// - Receive update carries user data bytes placed in this descriptor's buffer, zero padding excluded
// - Software notified per packet as it completes
// - Ring shared producer-consumer, no allocation
// - Card-to-system fetches descriptor then writes payload
// - One 12-byte descriptor update after payload
// - System-to-card fetches, reads buffer, then updates
// - Descriptor fetch returns 32 bytes
// - Payload requests split at 128 bytes
// - Two engines per direction, four rings
`timescale 1ns/1ps
`include "pdr_cfg.svh"

module pdr_dma_core
   import pdr_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             tlp_tx_valid,
   input  wire logic        tlp_tx_ready,
   output logic             tlp_tx_write,
   output logic [31:0]      tlp_tx_addr,
   output logic [7:0]       tlp_tx_len,
   output logic             tlp_tx_dvalid,
   input  wire logic        tlp_tx_dready,
   output logic [63:0]      tlp_tx_data,
   output logic             tlp_tx_dlast,
   input  wire logic        tlp_rx_valid,
   output logic             tlp_rx_ready,
   input  wire logic [63:0] tlp_rx_data,
   input  wire logic        tlp_rx_last,
   output logic             usr_out_valid,
   input  wire logic        usr_out_ready,
   output logic [63:0]      usr_out_data,
   output logic             usr_out_last,
   output logic [1:0]       usr_out_eng,
   input  wire logic        usr_in_valid,
   output logic             usr_in_ready,
   input  wire logic [63:0] usr_in_data,
   input  wire logic        usr_in_last,
   input  wire logic [31:0] usr_in_status,
   input  wire logic        usr_in_eng,
   output logic [3:0]       pkt_done
);
   // Per-ring pointer views
   pdr_word_t e_start [`PDR_NUM_ENG];
   pdr_word_t e_end   [`PDR_NUM_ENG];
   pdr_word_t e_next  [`PDR_NUM_ENG];
   pdr_word_t e_tail  [`PDR_NUM_ENG];
   pdr_word_t e_done  [`PDR_NUM_ENG];
   logic [3:0] e_en;
   logic [3:0] e_inpkt;
   logic [3:0] e_work;
   logic [3:0] e_adv;

   pdr_state_t  st_q;
   pdr_state_t  st_d;
   logic [1:0]  cur_q;
   logic [1:0]  rr_q;
   logic [4:0]  bcnt_q;
   logic [31:0] baddr_q;
   logic [19:0] rem_q;
   logic [19:0] act_q;
   logic [2:0]  flg_q;
   logic [31:0] ustat_q;
   logic        ended_q;
   logic        hdr_wr_q;
   logic [31:0] hdr_addr_q;
   logic [7:0]  hdr_len_q;
   logic        dv_q;
   logic [63:0] dat_q;
   logic        dlast_q;
   logic        uov_q;
   logic [63:0] uod_q;
   logic        uol_q;
   logic [31:0] prdata_q;
   logic [3:0]  done_q;

   // APB decode; zero-wait slave, error on unmapped words
   wire [1:0] a_eng  = paddr[`PDR_ENG_MSB:`PDR_ENG_LSB];
   wire [2:0] a_idx  = paddr[`PDR_IDX_MSB:`PDR_IDX_LSB];
   wire       a_hit  = (paddr[31:`PDR_HI_LSB] == 25'h000_0000) &&
                       (a_idx <= `PDR_REG_STAT);
   wire       a_setup = psel && !penable;
   wire       a_wr   = psel && penable && pwrite && a_hit;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !a_hit;
   assign prdata  = prdata_q;

   wire        is_c2s = cur_q[`PDR_C2S_BIT];
   wire [19:0] step8  = `PDR_BEAT_BYTES;
   wire [4:0]  beats  = 5'(hdr_len_q >> 3);
   wire        last_b = (5'(bcnt_q + 5'h01) == beats);

   // Chunk of a buffer, capped at max payload
   function automatic [7:0] chunk_of(input [19:0] r);
      chunk_of = (r > `PDR_MAX_PAYLOAD) ? 8'(`PDR_MAX_PAYLOAD) : 8'(r);
   endfunction

   wire [19:0] rem_nx  = rem_q - 20'(hdr_len_q);
   wire [31:0] addr_nx = baddr_q + 32'(hdr_len_q);
   wire        upd_go  = (rem_nx == 20'h0_0000) || ended_q;

   // One ring per engine, two each way
   genvar g;
   generate
      for (g = 0; g < `PDR_NUM_ENG; g++) begin : gen_eng
         pdr_ring_ptr u_ring (
            .pclk     (pclk),
            .presetn  (presetn),
            .we       (a_wr && a_eng == 2'(g)),
            .widx     (a_idx),
            .wdata    (pwdata),
            .adv      (e_adv[g]),
            .adv_eop  (s_eop),
            .start_q  (e_start[g]),
            .end_q    (e_end[g]),
            .next_q   (e_next[g]),
            .tail_q   (e_tail[g]),
            .done_q   (e_done[g]),
            .enable_q (e_en[g]),
            .in_pkt_q (e_inpkt[g]),
            .has_work (e_work[g])
         );
         assign e_adv[g] = (st_q == PDR_DONE) && (cur_q == 2'(g));
      end
   endgenerate

   // Read mux, captured in setup phase so data comes from a flop
   logic [31:0] rd_w;
   always_comb begin
      case (a_idx)
         `PDR_REG_CTRL:  rd_w = {31'h0000_0000, e_en[a_eng]};
         `PDR_REG_START: rd_w = e_start[a_eng];
         `PDR_REG_END:   rd_w = e_end[a_eng];
         `PDR_REG_NEXT:  rd_w = e_next[a_eng];
         `PDR_REG_TAIL:  rd_w = e_tail[a_eng];
         `PDR_REG_DONE:  rd_w = e_done[a_eng];
         `PDR_REG_STAT:  rd_w = {29'h0000_0000, e_inpkt[a_eng],
                                 e_work[a_eng],
                                 (st_q != PDR_IDLE) && cur_q == a_eng};
         default:        rd_w = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata_q <= 32'h0000_0000;
      else if (a_setup) prdata_q <= a_hit ? rd_w : 32'h0000_0000;
   end

   // Round-robin pick so one busy ring cannot starve others
   logic [1:0] pick;
   logic       pick_ok;
   always_comb begin
      logic [1:0] idx;
      idx     = 2'h0;
      pick    = 2'h0;
      pick_ok = 1'b0;
      for (int i = 1; i <= `PDR_NUM_ENG; i++) begin
         idx = 2'(rr_q + 2'(i));
         if (!pick_ok && e_work[idx]) begin
            pick    = idx;
            pick_ok = 1'b1;
         end
      end
   end

   // Handshakes
   wire rx_fire  = tlp_rx_valid && tlp_rx_ready;
   wire tx_fire  = tlp_tx_valid && tlp_tx_ready;
   wire d_fire   = dv_q && tlp_tx_dready;
   wire w_need   = (st_q == PDR_WDAT) && (bcnt_q < beats) &&
                   (!dv_q || tlp_tx_dready);
   wire eng_ok   = usr_in_eng == cur_q[0];
   wire w_take   = w_need && (ended_q || (usr_in_valid && eng_ok));
   wire uo_room  = !uov_q || usr_out_ready;

   assign tlp_tx_valid = (st_q == PDR_FREQ) || (st_q == PDR_DREQ) ||
                         (st_q == PDR_UREQ);
   assign tlp_tx_write = hdr_wr_q;
   assign tlp_tx_addr  = hdr_addr_q;
   assign tlp_tx_len   = hdr_len_q;
   assign tlp_tx_dvalid = dv_q;
   assign tlp_tx_data  = dat_q;
   assign tlp_tx_dlast = dlast_q;
   assign tlp_rx_ready = (st_q == PDR_FCPL) ||
                         ((st_q == PDR_RCPL) && uo_room);
   assign usr_in_ready = w_need && !ended_q && eng_ok;
   assign usr_out_valid = uov_q;
   assign usr_out_data  = uod_q;
   assign usr_out_last  = uol_q;
   assign usr_out_eng   = cur_q;
   assign pkt_done      = done_q;

   // Sequencer next state
   always_comb begin
      st_d = st_q;
      case (st_q)
         PDR_IDLE: if (pick_ok) st_d = PDR_FREQ;
         PDR_FREQ: if (tx_fire) st_d = PDR_FCPL;
         PDR_FCPL: if (rx_fire && tlp_rx_last)
                      st_d = (rem_q == 20'h0_0000) ? PDR_UREQ : PDR_DREQ;
         PDR_DREQ: if (tx_fire) st_d = is_c2s ? PDR_WDAT : PDR_RCPL;
         PDR_RCPL: if (rx_fire && last_b)
                      st_d = upd_go ? PDR_UREQ : PDR_DREQ;
         PDR_WDAT: if (d_fire && dlast_q)
                      st_d = upd_go ? PDR_UREQ : PDR_DREQ;
         PDR_UREQ: if (tx_fire) st_d = PDR_UDAT;
         PDR_UDAT: if (d_fire && dlast_q) st_d = PDR_DONE;
         PDR_DONE: st_d = PDR_IDLE;
         default:  st_d = PDR_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) st_q <= PDR_IDLE;
      else st_q <= st_d;
   end

   // Status word written back into the descriptor
   wire s_sop = is_c2s ? !e_inpkt[cur_q] : flg_q[0];
   wire s_eop = is_c2s ? ended_q : flg_q[1];
   wire [31:0] upd_st = {29'h0000_0000, s_eop, s_sop, 1'b1};

   // Request headers, loaded one state ahead so they come from flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hdr_wr_q   <= 1'b0;
         hdr_addr_q <= 32'h0000_0000;
         hdr_len_q  <= 8'h00;
         cur_q      <= 2'h0;
         rr_q       <= 2'h0;
      end else begin
         if (st_q == PDR_IDLE && pick_ok) begin
            cur_q      <= pick;
            rr_q       <= pick;
            hdr_wr_q   <= 1'b0;
            hdr_addr_q <= e_next[pick];
            hdr_len_q  <= `PDR_DESC_BYTES;
         end else if (st_q == PDR_FCPL && rx_fire && tlp_rx_last) begin
            hdr_wr_q   <= is_c2s;
            hdr_addr_q <= baddr_q;
            hdr_len_q  <= chunk_of(rem_q);
            if (rem_q == 20'h0_0000) begin
               hdr_wr_q   <= 1'b1;
               hdr_addr_q <= e_next[cur_q];
               hdr_len_q  <= `PDR_UPD_BYTES;
            end
         end else if ((st_q == PDR_RCPL && rx_fire && last_b) ||
                      (st_q == PDR_WDAT && d_fire && dlast_q)) begin
            if (upd_go) begin
               hdr_wr_q   <= 1'b1;
               hdr_addr_q <= e_next[cur_q];
               hdr_len_q  <= `PDR_UPD_BYTES;
            end else begin
               hdr_addr_q <= addr_nx;
               hdr_len_q  <= chunk_of(rem_nx);
            end
         end
      end
   end

   // Descriptor fields and progress through the buffer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bcnt_q  <= 5'h00;
         baddr_q <= 32'h0000_0000;
         rem_q   <= 20'h0_0000;
         act_q   <= 20'h0_0000;
         flg_q   <= 3'h0;
         ustat_q <= 32'h0000_0000;
         ended_q <= 1'b0;
      end else begin
         if (tx_fire) bcnt_q <= 5'h00;
         if (st_q == PDR_FCPL && rx_fire) begin
            bcnt_q <= 5'(bcnt_q + 5'h01);
            if (bcnt_q == 5'h00) begin
               rem_q <= tlp_rx_data[`PDR_LEN_MSB:0];
               flg_q <= tlp_rx_data[`PDR_FLG_IRQ:`PDR_FLG_SOP];
            end
            if (bcnt_q == 5'h01) baddr_q <= tlp_rx_data[31:0];
            act_q   <= 20'h0_0000;
            ustat_q <= 32'h0000_0000;
            ended_q <= 1'b0;
         end
         if (st_q == PDR_RCPL && rx_fire) begin
            bcnt_q <= 5'(bcnt_q + 5'h01);
            act_q  <= act_q + step8;
         end
         if (w_take) begin
            bcnt_q <= 5'(bcnt_q + 5'h01);
            if (!ended_q) begin
               act_q <= act_q + step8;
               if (usr_in_last) begin
                  ended_q <= 1'b1;
                  ustat_q <= usr_in_status;
               end
            end
         end
         if ((st_q == PDR_RCPL && rx_fire && last_b) ||
             (st_q == PDR_WDAT && d_fire && dlast_q)) begin
            rem_q   <= rem_nx;
            baddr_q <= addr_nx;
         end
      end
   end

   // Write data beats: payload, then two update beats (12 bytes)
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dv_q    <= 1'b0;
         dat_q   <= 64'h0000_0000_0000_0000;
         dlast_q <= 1'b0;
      end else if (w_take) begin
         dv_q    <= 1'b1;
         dat_q   <= ended_q ? 64'h0000_0000_0000_0000 : usr_in_data;
         dlast_q <= last_b;
      end else if (st_q == PDR_UREQ && tx_fire) begin
         dv_q    <= 1'b1;
         dat_q   <= {12'h000, act_q, upd_st};
         dlast_q <= 1'b0;
      end else if (st_q == PDR_UDAT && d_fire && !dlast_q) begin
         dat_q   <= {32'h0000_0000, ustat_q};
         dlast_q <= 1'b1;
      end else if (d_fire) begin
         dv_q    <= 1'b0;
         dlast_q <= 1'b0;
      end
   end

   // Completion payload towards the user side, one stage deep
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         uov_q <= 1'b0;
         uod_q <= 64'h0000_0000_0000_0000;
         uol_q <= 1'b0;
      end else if (st_q == PDR_RCPL && rx_fire) begin
         uov_q <= 1'b1;
         uod_q <= tlp_rx_data;
         uol_q <= flg_q[1] && last_b && (rem_nx == 20'h0_0000);
      end else if (usr_out_ready) begin
         uov_q <= 1'b0;
         uol_q <= 1'b0;
      end
   end

   // Per-packet notice, not batched by count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) done_q <= 4'h0;
      else done_q <= e_adv & {4{s_eop || flg_q[2]}};
   end
endmodule

// ===== core/pdr_pkg.sv
package pdr_pkg;
   typedef enum logic [8:0] {
      PDR_IDLE = 9'h001,
      PDR_FREQ = 9'h002,
      PDR_FCPL = 9'h004,
      PDR_DREQ = 9'h008,
      PDR_RCPL = 9'h010,
      PDR_WDAT = 9'h020,
      PDR_UREQ = 9'h040,
      PDR_UDAT = 9'h080,
      PDR_DONE = 9'h100
   } pdr_state_t;
   typedef logic [31:0] pdr_word_t;
endpackage

// ===== core/pdr_ring_ptr.sv
`timescale 1ns/1ps
`include "pdr_cfg.svh"

// Pointer set of one descriptor ring
module pdr_ring_ptr
   import pdr_pkg::*;
(
   input  wire logic      pclk,
   input  wire logic      presetn,
   input  wire logic      we,
   input  wire logic [2:0] widx,
   input  wire pdr_word_t wdata,
   input  wire logic      adv,
   input  wire logic      adv_eop,
   output pdr_word_t      start_q,
   output pdr_word_t      end_q,
   output pdr_word_t      next_q,
   output pdr_word_t      tail_q,
   output pdr_word_t      done_q,
   output logic           enable_q,
   output logic           in_pkt_q,
   output logic           has_work
);
   wire pdr_word_t step_w = next_q + `PDR_ADDR_STEP;
   wire pdr_word_t wrap_w = (next_q == end_q) ? start_q : step_w;

   // Engine owns next..tail; equal pointers park it
   assign has_work = enable_q && (next_q != tail_q);

   // Hardware advance beats a same-cycle software write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_q  <= 32'h0000_0000;
         end_q    <= 32'h0000_0000;
         next_q   <= 32'h0000_0000;
         tail_q   <= 32'h0000_0000;
         done_q   <= 32'h0000_0000;
         enable_q <= 1'b0;
         in_pkt_q <= 1'b0;
      end else begin
         if (we && widx == `PDR_REG_CTRL) enable_q <= wdata[0];
         if (we && widx == `PDR_REG_START) start_q <= wdata;
         if (we && widx == `PDR_REG_END) end_q <= wdata;
         if (we && widx == `PDR_REG_TAIL) tail_q <= wdata;
         if (adv) begin
            done_q   <= next_q;
            next_q   <= wrap_w;
            in_pkt_q <= !adv_eop;
         end else begin
            if (we && widx == `PDR_REG_NEXT) next_q <= wdata;
            if (we && widx == `PDR_REG_DONE) done_q <= wdata;
         end
      end
   end
endmodule

// ===== tb/pdr_dma_core_props.sv
`timescale 1ns/1ps
// Pin-level watcher of the ring core
module pdr_dma_core_props (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] paddr,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        tlp_tx_valid,
   input wire logic        tlp_tx_ready,
   input wire logic        tlp_tx_write,
   input wire logic [31:0] tlp_tx_addr,
   input wire logic [7:0]  tlp_tx_len,
   input wire logic        tlp_tx_dvalid,
   input wire logic        tlp_tx_dready,
   input wire logic [63:0] tlp_tx_data,
   input wire logic        usr_out_valid,
   input wire logic        usr_out_ready,
   input wire logic [63:0] usr_out_data,
   input wire logic [3:0]  pkt_done
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Zero-wait slave, so a pointer write lands in its access phase
   apb_ready_a: assert property (psel && penable |-> pready)
      else $error("access phase without pready");
   unmapped_err_a: assert property (psel && penable && paddr[31:7] == '0
      && paddr[4:2] == 3'h7 |-> pslverr) else $error("hole not refused");
   err_phase_a: assert property (!(psel && penable) |-> !pslverr)
      else $error("pslverr outside access");
   // Requests and beats must hold while the host or the user sink stalls
   hdr_hold_a: assert property (tlp_tx_valid && !tlp_tx_ready |=>
      tlp_tx_valid && $stable({tlp_tx_write, tlp_tx_addr, tlp_tx_len}))
      else $error("request header dropped");
   beat_hold_a: assert property (tlp_tx_dvalid && !tlp_tx_dready |=>
      tlp_tx_dvalid && $stable(tlp_tx_data)) else $error("beat dropped");
   out_hold_a: assert property (usr_out_valid && !usr_out_ready |=>
      usr_out_valid && $stable(usr_out_data)) else $error("out dropped");
   // Sizes: payload writes capped, update is 12 bytes at a slot
   wr_size_a: assert property (tlp_tx_valid && tlp_tx_write |->
      tlp_tx_len <= 8'h80 && (tlp_tx_len[2:0] == 3'h0 || tlp_tx_len == 8'h0c))
      else $error("write length out of range");
   upd_slot_a: assert property (tlp_tx_valid && tlp_tx_len == 8'h0c |->
      tlp_tx_write && tlp_tx_addr[4:0] == 5'h00) else $error("bad update");
   rd_size_a: assert property (tlp_tx_valid && !tlp_tx_write |->
      tlp_tx_len != 8'h00 && tlp_tx_len <= 8'h80 && tlp_tx_len[2:0] == 3'h0)
      else $error("read length out of range");
   done_pulse_a: assert property (pkt_done != 4'h0 |->
      $onehot(pkt_done) ##1 pkt_done == 4'h0) else $error("done not a pulse");
endmodule

bind pdr_dma_core pdr_dma_core_props u_props (.pclk, .presetn, .psel,
   .penable, .paddr, .pready, .pslverr, .tlp_tx_valid, .tlp_tx_ready,
   .tlp_tx_write, .tlp_tx_addr, .tlp_tx_len, .tlp_tx_dvalid, .tlp_tx_dready,
   .tlp_tx_data, .usr_out_valid, .usr_out_ready, .usr_out_data, .pkt_done);

// ===== tb/pdr_host_model.sv
`timescale 1ns/1ps
// Host memory behind the transaction ports; slow adds stalls
module pdr_host_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        slow,
   input  wire logic        tlp_tx_valid,
   output logic             tlp_tx_ready,
   input  wire logic        tlp_tx_write,
   input  wire logic [31:0] tlp_tx_addr,
   input  wire logic [7:0]  tlp_tx_len,
   input  wire logic        tlp_tx_dvalid,
   output logic             tlp_tx_dready,
   input  wire logic [63:0] tlp_tx_data,
   output logic             tlp_rx_valid,
   input  wire logic        tlp_rx_ready,
   output logic [63:0]      tlp_rx_data,
   output logic             tlp_rx_last
);
   logic [63:0] mem [logic [28:0]];
   logic [31:0] rd_a[$];
   logic [7:0]  rd_n[$];
   logic [31:0] wr_a;
   logic [2:0]  cnt;
   // Stall patterns only when asked for
   assign tlp_tx_ready  = !slow || cnt[1];
   assign tlp_tx_dready = !slow || cnt[0];
   // One shared ring memory, nothing allocated on the fly
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 3'h0;
         tlp_rx_valid <= 1'b0;
         tlp_rx_data <= 64'h0;
         tlp_rx_last <= 1'b0;
      end else begin
         cnt <= cnt + 3'h1;
         if (tlp_tx_valid && tlp_tx_ready && tlp_tx_write)
            wr_a <= tlp_tx_addr;
         if (tlp_tx_valid && tlp_tx_ready && !tlp_tx_write) begin
            rd_a.push_back(tlp_tx_addr);
            rd_n.push_back(tlp_tx_len >> 3);
         end
         if (tlp_tx_dvalid && tlp_tx_dready) begin
            mem[wr_a[31:3]] = tlp_tx_data;
            wr_a <= wr_a + 32'h8;
         end
         // Completions return each read whole, in order, held until taken
         if (tlp_rx_valid && tlp_rx_ready) begin
            rd_a[0] = rd_a[0] + 32'h8;
            rd_n[0] = rd_n[0] - 8'h1;
            if (rd_n[0] == 8'h0) begin
               void'(rd_a.pop_front());
               void'(rd_n.pop_front());
            end
         end
         if (!(tlp_rx_valid && !tlp_rx_ready)) begin
            if (rd_a.size() != 0 && (!slow || cnt[2])) begin
               tlp_rx_valid <= 1'b1;
               tlp_rx_data <= mem[rd_a[0][31:3]];
               tlp_rx_last <= rd_n[0] == 8'h1;
            end else begin
               tlp_rx_valid <= 1'b0;
               tlp_rx_data <= ~tlp_rx_data;
            end
         end
      end
   end
endmodule

// ===== tb/test_packet_dma_descriptor_ring.sv
`timescale 1ns/1ps
module test_packet_dma_descriptor_ring;
   localparam logic [31:0] rxr = 32'h0000_1000;
   localparam logic [31:0] txr = 32'h0000_3000;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [31:0] paddr, pwdata, prdata, rv, usr_in_status, seed, tlp_tx_addr;
   logic        tlp_tx_valid, tlp_tx_ready, tlp_tx_write, tlp_tx_dvalid;
   logic        tlp_tx_dready, tlp_tx_dlast, tlp_rx_valid, tlp_rx_ready;
   logic        tlp_rx_last, usr_out_valid, usr_out_ready, usr_out_last;
   logic        usr_in_valid, usr_in_ready, usr_in_last, usr_in_eng, slow;
   logic [7:0]  tlp_tx_len;
   logic [63:0] tlp_tx_data, tlp_rx_data, usr_out_data, usr_in_data, m;
   logic [1:0]  usr_out_eng;
   logic [3:0]  pkt_done, cyc;
   logic [63:0] pay[$], exp_out[$];
   int          bad_count, compares, done_n[4];
   pdr_dma_core DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .tlp_tx_valid, .tlp_tx_ready,
      .tlp_tx_write, .tlp_tx_addr, .tlp_tx_len, .tlp_tx_dvalid,
      .tlp_tx_dready, .tlp_tx_data, .tlp_tx_dlast, .tlp_rx_valid,
      .tlp_rx_ready, .tlp_rx_data, .tlp_rx_last, .usr_out_valid,
      .usr_out_ready, .usr_out_data, .usr_out_last, .usr_out_eng,
      .usr_in_valid, .usr_in_ready, .usr_in_data, .usr_in_last,
      .usr_in_status, .usr_in_eng, .pkt_done);
   pdr_host_model u_host (.pclk, .presetn, .slow, .tlp_tx_valid,
      .tlp_tx_ready, .tlp_tx_write, .tlp_tx_addr, .tlp_tx_len,
      .tlp_tx_dvalid, .tlp_tx_dready, .tlp_tx_data, .tlp_rx_valid,
      .tlp_rx_ready, .tlp_rx_data, .tlp_rx_last);
   // 200 MHz clock
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [31:0] ra(input int e, input int i);
      return 32'(e * 32 + i * 4);
   endfunction
   function automatic logic [63:0] mw(input logic [31:0] a);
      return u_host.mem[a[31:3]];
   endfunction
   task automatic report_and_stop();
      $display("bad_count=%0d compares=%0d", bad_count, compares);
      if (bad_count == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Wait for a level seen at a rising edge
   task automatic wait_hi(ref logic s);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (s !== 1'b1 && n < 900);
      if (n >= 900) begin
         bad_count++;
         report_and_stop();
      end
   endtask
   task automatic apb(input logic wr, input logic [31:0] a, d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      wait_hi(pready);
      rv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wait_reg(input logic [31:0] a, exp);
      int n;
      n = 0;
      do begin
         apb(1'b0, a, 32'h0);
         n++;
      end while (rv !== exp && n < 300);
      chk(rv, exp);
   endtask
   task automatic setup(input int e, input logic [31:0] s, en, nx, tl);
      apb(1'b1, ra(e, 1), s);
      apb(1'b1, ra(e, 2), en);
      apb(1'b1, ra(e, 3), nx);
      apb(1'b1, ra(e, 4), tl);
      apb(1'b1, ra(e, 5), 32'h0);
      apb(1'b1, ra(e, 0), 32'h1);
   endtask
   task automatic desc(input logic [31:0] a, input logic [19:0] n,
         input logic [2:0] fl, input logic [31:0] b);
      u_host.mem[a[31:3]] = {29'h0, fl, 12'h0, n};
      u_host.mem[a[31:3] + 29'h1] = {32'h0, b};
      u_host.mem[a[31:3] + 29'h2] = 64'h0;
      u_host.mem[a[31:3] + 29'h3] = 64'h0;
   endtask
   task automatic send(input int n, input logic [31:0] st);
      logic [63:0] d;
      for (int k = 0; k < n; k++) begin
         d = {rnd(), rnd()};
         usr_in_valid <= 1'b1;
         usr_in_data <= d;
         usr_in_last <= k == n - 1;
         usr_in_status <= st;
         wait_hi(usr_in_ready);
         pay.push_back(d);
      end
      usr_in_valid <= 1'b0;
      @(posedge pclk);
   endtask
   // User sink stalls two cycles in eight; scoreboard of its beats
   always @(posedge pclk) begin
      cyc <= cyc + 4'h1;
      usr_out_ready <= cyc[2:1] != 2'h3;
      if (usr_out_valid === 1'b1 && usr_out_ready === 1'b1) begin
         chk({usr_out_last, usr_out_eng}, {exp_out.size() == 1, 2'h0});
         if (exp_out.size() == 0)
            chk(64'h1, 64'h0);
         else
            chk(usr_out_data, exp_out.pop_front());
      end
      for (int e = 0; e < 4; e++)
         if (pkt_done[e] === 1'b1)
            done_n[e]++;
   end
   initial begin
      {psel, penable, pwrite, usr_in_valid, usr_in_last, usr_in_eng} = '0;
      {paddr, pwdata, usr_in_data, usr_in_status} = '0;
      {usr_out_ready, slow, cyc, presetn} = '0;
      seed = 32'h0001_2229;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // Reset value, the hole in a window, a second-engine register
      apb(1'b0, ra(2, 5), 32'h0);
      chk(rv, 32'h0);
      apb(1'b0, ra(1, 7), 32'h0);
      chk({err, rv}, {1'b1, 32'h0});
      apb(1'b1, ra(1, 1), 32'h0000_5000);
      apb(1'b0, ra(1, 1), 32'h0);
      chk(rv, 32'h0000_5000);
      setup(3, 32'h0000_2000, 32'h0000_2060, 32'h0000_2000, 32'h0000_2000);
      // Receive under a stalling host: a packet over two buffers
      slow <= 1'b1;
      desc(rxr, 20'h0_00a0, 3'h0, 32'h0000_8000);
      desc(rxr + 32'h20, 20'h0_0010, 3'h0, 32'h0000_9000);
      setup(2, rxr, rxr + 32'h40, rxr, rxr + 32'h40);
      send(21, 32'h0000_00a5);
      wait_reg(ra(2, 5), rxr + 32'h20);
      apb(1'b0, ra(2, 3), 32'h0);
      chk(rv, rxr + 32'h40);
      for (int k = 0; k < 20; k++)
         chk(mw(32'h0000_8000 + 8 * k), pay[k]);
      chk(mw(32'h0000_9000), pay[20]);
      chk(mw(32'h0000_9008), 64'h0);
      m = mw(rxr);
      chk({m[51:32], m[2:0]}, {20'h0_00a0, 3'h3});
      m = mw(rxr + 32'h20);
      chk({m[51:32], m[2:0]}, {20'h0_0008, 3'h5});
      chk(mw(rxr + 32'h28), 64'h0000_0000_0000_00a5);
      // Return the ring end; engine wraps to start
      pay.delete();
      desc(rxr + 32'h40, 20'h0_0008, 3'h0, 32'h0000_9800);
      apb(1'b1, ra(2, 4), rxr);
      send(1, 32'h0000_005a);
      wait_reg(ra(2, 5), rxr + 32'h40);
      apb(1'b0, ra(2, 3), 32'h0);
      chk(rv, rxr);
      chk(mw(32'h0000_9800), pay[0]);
      m = mw(rxr + 32'h40);
      chk({m[51:32], m[2:0]}, {20'h0_0008, 3'h7});
      chk(done_n[2], 2);
      // Transmit: one flagged descriptor read in two pieces
      slow <= 1'b0;
      desc(txr, 20'h0_0088, 3'h7, 32'h0000_a000);
      for (int k = 0; k < 17; k++) begin
         m = {rnd(), rnd()};
         u_host.mem[29'h0000_1400 + 29'(k)] = m;
         exp_out.push_back(m);
      end
      setup(0, txr, txr + 32'h20, txr, txr);
      apb(1'b1, ra(0, 4), txr + 32'h20);
      wait_reg(ra(0, 5), txr);
      m = mw(txr);
      chk(m[2:0], 3'h7);
      chk(exp_out.size(), 0);
      chk(done_n[0], 1);
      apb(1'b0, ra(3, 3), 32'h0);
      chk(rv, 32'h0000_2000);
      report_and_stop();
   end
endmodule
